/* File: hw/pol_pkg.sv */
// package: register map, field layout, timing and carrier types of the
// load-converter fault and pwm controller.
// assumes a 40 MHz bus clock shared by the whole block.
package pol_pkg;

  // clock and timing
  localparam int CLK_HZ        = 40_000_000;
  localparam int HICCUP_MS     = 130;
  localparam int HICCUP_CYC    = HICCUP_MS * (CLK_HZ / 1000);
  localparam int HIC_W         = 23;
  localparam int FSW_LOW_HZ    = 500_000;
  localparam int FSW_MID_HZ    = 750_000;
  localparam int FSW_HIGH_HZ   = 1_000_000;
  localparam logic [6:0] PER_LOW  = 7'(CLK_HZ / FSW_LOW_HZ);
  localparam logic [6:0] PER_MID  = 7'(CLK_HZ / FSW_MID_HZ);
  localparam logic [6:0] PER_HIGH = 7'(CLK_HZ / FSW_HIGH_HZ);

  // frequency select codes
  localparam logic [1:0] FSEL_LOW  = 2'h0;
  localparam logic [1:0] FSEL_MID  = 2'h1;
  localparam logic [1:0] FSEL_HIGH = 2'h2;

  // saturation window around the setpoint, in error units
  localparam logic signed [7:0] SAT_WIN = 8'sh10;

  // register word indices (byte address = 4 * index)
  localparam logic [2:0] IDX_CTRL   = 3'h0;
  localparam logic [2:0] IDX_INTLV  = 3'h1;
  localparam logic [2:0] IDX_DUTY   = 3'h2;
  localparam logic [2:0] IDX_SEQ    = 3'h3;
  localparam logic [2:0] IDX_STATUS = 3'h4;

  // control register fields
  localparam int CTRL_ON    = 0;
  localparam int CTRL_GPROP = 1;
  localparam int CTRL_SPROP = 2;
  localparam int CTRL_RETRY = 3;
  localparam int CTRL_TRACK = 4;
  // interleave register fields
  localparam int INTLV_FSEL = 0;
  localparam int INTLV_PH   = 2;
  // duty limit register fields
  localparam int DUTY_LIM   = 0;
  localparam int DUTY_SAT   = 8;
  // sequencing register fields
  localparam int SEQ_DLY    = 0;
  localparam int SEQ_FALL   = 8;
  localparam int SEQ_RISE   = 16;
  // status register fields
  localparam int STAT_CAUSE = 0;
  localparam int STAT_STATE = 8;
  localparam int STAT_PG    = 11;
  localparam int STAT_TW    = 12;

  // cause bit positions
  localparam int C_OT = 0;
  localparam int C_OC = 1;
  localparam int C_UV = 2;
  localparam int C_TR = 3;
  localparam int C_OV = 4;
  localparam int C_PF = 5;
  localparam int C_PE = 6;
  localparam int C_TW = 7;

  // reset values
  localparam logic [4:0] CTRL_RST  = 5'h18;
  localparam logic [7:0] LIM_RST   = 8'hC0;
  localparam logic [7:0] DLY_RST   = 8'h04;
  localparam logic [7:0] FALL_RST  = 8'h08;
  localparam logic [7:0] RISE_RST  = 8'h08;

  typedef enum logic [2:0] {
    ST_OFF, ST_RAMP_UP, ST_STEADY, ST_OFF_DELAY, ST_RAMP_DOWN, ST_HICCUP, ST_LATCHED
  } pol_state_t;

  // analog comparator results, already qualified by the front end
  typedef struct packed {
    logic vin_ok;
    logic above_prebias;
    logic hot;
    logic warm;
    logic overcurrent;
    logic low_output;
    logic high_output;
    logic track_miss;
    logic in_window;
  } checks_t;

  typedef struct packed {
    pol_state_t  st;
    logic [4:0]  ctrl;
    logic [1:0]  fsel;
    logic [4:0]  phase;
    logic [7:0]  lim;
    logic        sat_en;
    logic [7:0]  dly;
    logic [7:0]  fall;
    logic [7:0]  rise;
    logic [7:0]  cause;
    logic [7:0]  duty;
    logic [6:0]  thr;
    logic [6:0]  cnt;
    logic [6:0]  ph_cnt;
    logic        ph_pend;
    logic        sync_prev;
    logic [7:0]  dly_cnt;
    logic [HIC_W-1:0] hic_cnt;
    logic [7:0]  level;
    logic        latch;
    logic        self_flt;
    logic        self_err;
    logic        ls_hold;
    logic        hs;
    logic        ls;
    logic        pg;
    logic        tw;
    logic        ahb_wr;
    logic [2:0]  ahb_idx;
    logic [31:0] hrdata;
  } regs_t;

endpackage

/* File: hw/pol_fault_and_pwm_control.sv */
// fault handling, hiccup restart and pwm generation for one load converter,
// with its registers on an ahb-lite slave port.
// assumes all inputs synchronous to hclk; shared lines are open drain and
// resolved outside.
`timescale 1ns/10ps
module pol_fault_and_pwm_control
  import pol_pkg::*;
#(
  parameter int HICCUP_CYCLES = HICCUP_CYC
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // manager links
  input  wire logic        sync_line,
  input  wire logic        fault_line_i,
  output logic             fault_line_o,
  output logic             fault_line_oe_n,
  input  wire logic        error_line_i,
  output logic             error_line_o,
  output logic             error_line_oe_n,
  // power stage
  input  wire checks_t     checks,
  input  wire logic signed [7:0] err_sample,
  output logic             hs_gate,
  output logic             ls_gate,
  output logic      [7:0]  out_level,
  output logic             output_within_window,
  output logic             temperature_warning
);

  // the hiccup-length assertion needs more than eight clocks in the state
  if (HICCUP_CYCLES < 16 || HICCUP_CYCLES >= (1 << HIC_W)) begin : g_bad_hiccup
    $error("HICCUP_CYCLES out of range");
  end

  localparam logic [HIC_W-1:0] HIC_LAST = HIC_W'(HICCUP_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////
  // functions

  function automatic logic [6:0] period_of(input logic [1:0] sel);
    logic [6:0] p;
    p = PER_LOW;
    unique case (sel)
      FSEL_MID:  p = PER_MID;
      FSEL_HIGH: p = PER_HIGH;
      default:   p = PER_LOW;
    endcase
    return p;
  endfunction

  // phase offset in clocks: period * steps / 32, one step = 11.25 degrees
  function automatic logic [6:0] phase_delay(input logic [6:0] per, input logic [4:0] steps);
    logic [11:0] prod;
    prod = 12'(per) * 12'(steps);
    return prod[11:5];
  endfunction

  function automatic logic [7:0] next_duty(input logic [7:0] duty, input logic [7:0] lim,
                                           input logic signed [7:0] e, input logic sat);
    logic signed [9:0] v;
    v = 10'(signed'({2'b00, duty})) + 10'(e >>> 2);
    if (sat && e > SAT_WIN)
      v = 10'(signed'({2'b00, lim}));
    else if (sat && e < -SAT_WIN)
      v = 10'sh000;
    if (v < 0)
      v = 10'sh000;
    if (v > 10'(signed'({2'b00, lim})))
      v = 10'(signed'({2'b00, lim}));
    return v[7:0];
  endfunction

  function automatic logic [31:0] rd_word(input regs_t r, input logic [2:0] idx);
    logic [31:0] w;
    w = 32'h0000_0000;
    unique case (idx)
      IDX_CTRL:   w[4:0] = r.ctrl;
      IDX_INTLV:  w[INTLV_PH+4:INTLV_FSEL] = {r.phase, r.fsel};
      IDX_DUTY:   w[DUTY_SAT:DUTY_LIM] = {r.sat_en, r.lim};
      IDX_SEQ:    w[SEQ_RISE+7:SEQ_DLY] = {r.rise, r.fall, r.dly};
      IDX_STATUS: begin
        w[STAT_CAUSE+7:STAT_CAUSE] = r.cause;
        w[STAT_STATE+2:STAT_STATE] = r.st;
        w[STAT_PG]                 = r.pg;
        w[STAT_TW]                 = r.tw;
      end
      default:    w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next state

  regs_t q;
  regs_t d;
  logic [7:0] set_c;
  logic [7:0] clr_c;
  logic       cyc;
  logic       is_off;
  logic       running;
  logic       active;
  logic       pe_rx;
  logic       pf_rx;
  logic       ov_hit;
  logic       oc_hit;
  logic       tr_hit;
  logic       uv_hit;
  logic       ot_hit;
  logic       sel_ok;
  logic [6:0] per;

  always_comb begin
    d       = q;
    set_c   = 8'h00;
    clr_c   = 8'h00;
    cyc     = 1'b0;
    per     = period_of(q.fsel);
    is_off  = (q.st == ST_OFF) || (q.st == ST_HICCUP) || (q.st == ST_LATCHED);
    running = (q.st == ST_RAMP_UP) || (q.st == ST_STEADY);
    active  = running || (q.st == ST_OFF_DELAY) || (q.st == ST_RAMP_DOWN);

    // ahb data phase: write lands one cycle after its address phase
    if (q.ahb_wr) begin
      unique case (q.ahb_idx)
        IDX_CTRL:  d.ctrl = hwdata[4:0];
        IDX_INTLV: begin
          d.phase = hwdata[INTLV_PH+4:INTLV_PH];
          // frequency is per converter and frozen while switching
          if (is_off && hwdata[INTLV_FSEL+1:INTLV_FSEL] != 2'h3)
            d.fsel = hwdata[INTLV_FSEL+1:INTLV_FSEL];
        end
        IDX_DUTY: begin
          d.lim    = hwdata[DUTY_LIM+7:DUTY_LIM];
          d.sat_en = hwdata[DUTY_SAT];
        end
        IDX_SEQ: begin
          d.dly  = hwdata[SEQ_DLY+7:SEQ_DLY];
          d.fall = hwdata[SEQ_FALL+7:SEQ_FALL];
          d.rise = hwdata[SEQ_RISE+7:SEQ_RISE];
        end
        IDX_STATUS: clr_c = hwdata[STAT_CAUSE+7:STAT_CAUSE];
        default: ;
      endcase
    end

    // ahb address phase; zero wait state, read data captured here
    sel_ok    = hsel && htrans[1] && hready;
    d.ahb_wr  = sel_ok && hwrite && (haddr[7:5] == 3'h0);
    d.ahb_idx = haddr[4:2];
    if (sel_ok && !hwrite)
      d.hrdata = (haddr[7:5] == 3'h0) ? rd_word(q, haddr[4:2]) : 32'h0000_0000;

    // sync edge restarts the switching period after the interleave delay
    d.sync_prev = sync_line;
    if (sync_line && !q.sync_prev) begin
      d.ph_cnt  = phase_delay(per, q.phase);
      d.ph_pend = 1'b1;
    end else if (q.ph_pend) begin
      if (q.ph_cnt == 7'h00)
        d.ph_pend = 1'b0;
      else
        d.ph_cnt = q.ph_cnt - 7'h01;
    end
    if ((q.ph_pend && q.ph_cnt == 7'h00 && !(sync_line && !q.sync_prev)) || q.cnt >= per - 7'h01) begin
      d.cnt = 7'h00;
      cyc   = 1'b1;
    end else begin
      d.cnt = q.cnt + 7'h01;
    end

    // duty loop, updated once per switching cycle
    if (cyc) begin
      if (running)
        d.duty = next_duty(q.duty, q.lim, err_sample, q.sat_en);
      else
        d.duty = 8'h00;
    end
    // clamp against the limit being written now, so a lowered limit bites at once
    if (d.duty > d.lim)
      d.duty = d.lim;
    d.thr = 7'((16'(d.duty) * 16'(per)) >> 8);

    // protection checks, each gated by its own operating window
    ot_hit = checks.vin_ok && checks.hot;
    ov_hit = checks.above_prebias && checks.high_output && running;
    oc_hit = checks.above_prebias && checks.overcurrent && running;
    tr_hit = (q.st == ST_RAMP_UP) && q.ctrl[CTRL_TRACK] && checks.track_miss;
    uv_hit = (q.st == ST_STEADY) && checks.low_output;
    pe_rx  = !error_line_i && !q.self_err;
    pf_rx  = !fault_line_i && !q.self_flt;
    set_c[C_OT] = ot_hit;
    set_c[C_OV] = ov_hit;
    set_c[C_OC] = oc_hit;
    set_c[C_TR] = tr_hit;
    set_c[C_UV] = uv_hit;
    set_c[C_TW] = checks.vin_ok && checks.warm;
    d.tw = checks.vin_ok && checks.warm;
    d.pg = (q.st == ST_STEADY) && checks.in_window;

    unique case (q.st)
      ST_OFF: begin
        d.level = 8'h00;
        if (q.ctrl[CTRL_ON] && fault_line_i && error_line_i)
          d.st = ST_RAMP_UP;
      end
      ST_RAMP_UP: begin
        if (cyc)
          d.level = (q.level > 8'hFF - q.rise) ? 8'hFF : q.level + q.rise;
        if (cyc && d.level == 8'hFF)
          d.st = ST_STEADY;
      end
      ST_STEADY: ;
      ST_OFF_DELAY: begin
        if (cyc) begin
          if (q.dly_cnt == 8'h00)
            d.st = ST_RAMP_DOWN;
          else
            d.dly_cnt = q.dly_cnt - 8'h01;
        end
      end
      ST_RAMP_DOWN: begin
        if (cyc)
          d.level = (q.level < q.fall) ? 8'h00 : q.level - q.fall;
        if (cyc && d.level == 8'h00) begin
          d.st      = q.latch ? ST_LATCHED : ST_HICCUP;
          d.hic_cnt = '0;
        end
      end
      ST_HICCUP: begin
        // counted from zero output, so turn-off delay does not stretch it
        if (q.hic_cnt == HIC_LAST) begin
          d.self_flt = 1'b0;
          d.st       = q.ctrl[CTRL_ON] ? ST_RAMP_UP : ST_OFF;
        end else begin
          d.hic_cnt = q.hic_cnt + HIC_W'(1);
        end
      end
      ST_LATCHED: begin
        if (!q.ctrl[CTRL_ON]) begin
          d.st       = ST_OFF;
          d.self_flt = 1'b0;
          d.self_err = 1'b0;
          d.ls_hold  = 1'b0;
        end
      end
    endcase

    // shutdown entry, errors first, then fast faults, then regular faults
    if (active) begin
      if (ov_hit || pe_rx) begin
        d.st       = ST_LATCHED;
        d.level    = 8'h00;
        d.latch    = 1'b1;
        d.self_err = ov_hit || q.self_err;
        d.ls_hold  = ov_hit;
        set_c[C_PE] = pe_rx;
      end else if (oc_hit || tr_hit) begin
        d.st       = q.ctrl[CTRL_RETRY] ? ST_HICCUP : ST_LATCHED;
        d.level    = 8'h00;
        d.hic_cnt  = '0;
        d.self_flt = 1'b1;
        d.latch    = !q.ctrl[CTRL_RETRY];
      end else if ((uv_hit || (ot_hit && running) || pf_rx) &&
                   q.st != ST_OFF_DELAY && q.st != ST_RAMP_DOWN) begin
        d.st       = ST_OFF_DELAY;
        d.dly_cnt  = q.dly;
        d.self_flt = uv_hit || ot_hit || q.self_flt;
        d.latch    = !q.ctrl[CTRL_RETRY];
        set_c[C_PF] = pf_rx;
      end
    end

    // hardware set wins over a software clear in the same cycle
    d.cause = (q.cause & ~clr_c) | set_c;

    // gate drive: both off outside the active states, low side held after an overvoltage
    d.hs = (d.st == ST_RAMP_UP || d.st == ST_STEADY || d.st == ST_OFF_DELAY || d.st == ST_RAMP_DOWN)
           && (d.cnt < d.thr);
    d.ls = d.ls_hold || ((d.st == ST_RAMP_UP || d.st == ST_STEADY || d.st == ST_OFF_DELAY ||
                          d.st == ST_RAMP_DOWN) && !d.hs);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q           <= '0;
      q.st        <= ST_OFF;
      q.ctrl      <= CTRL_RST;
      q.fsel      <= FSEL_LOW;
      q.lim       <= LIM_RST;
      q.dly       <= DLY_RST;
      q.fall      <= FALL_RST;
      q.rise      <= RISE_RST;
      q.sync_prev <= 1'b1;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign hrdata               = q.hrdata;
  assign hreadyout            = 1'b1;
  assign hresp                = 1'b0;
  assign fault_line_o         = 1'b0;
  assign fault_line_oe_n      = !(q.self_flt && (q.ctrl[CTRL_GPROP] || q.ctrl[CTRL_SPROP]));
  assign error_line_o         = 1'b0;
  assign error_line_oe_n      = !(q.self_err && (q.ctrl[CTRL_GPROP] || q.ctrl[CTRL_SPROP]));
  assign hs_gate              = q.hs;
  assign ls_gate              = q.ls;
  assign out_level            = q.level;
  assign output_within_window = q.pg;
  assign temperature_warning  = q.tw;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_hiccup_done;
    (q.st == ST_HICCUP) && (q.hic_cnt == HIC_LAST);
  endsequence
  sequence s_restart;
    (q.st == ST_RAMP_UP) && (q.level == 8'h00);
  endsequence

  a_duty_under_limit: assert property (q.duty <= q.lim)
    else $error("duty above limit");
  a_freq_when_off: assert property ($changed(q.fsel) |-> $past(q.st) inside {ST_OFF, ST_HICCUP, ST_LATCHED})
    else $error("frequency changed while running");
  a_freq_legal: assert property (q.fsel != 2'h3)
    else $error("illegal frequency select");
  a_ov_fast_off: assert property (ov_hit && active |=> !q.hs && q.ls && q.level == 8'h00)
    else $error("overvoltage did not force low side on");
  a_oc_fast_off: assert property (oc_hit && !ov_hit && !pe_rx && active |=> !q.hs && !q.ls)
    else $error("overcurrent did not drop both switches");
  a_prop_regular: assert property (pf_rx && running && !ov_hit && !oc_hit && !tr_hit && !pe_rx
                                   |=> q.st == ST_OFF_DELAY)
    else $error("propagated fault not a regular turn-off");
  a_hiccup_restart: assert property (s_hiccup_done ##0 q.ctrl[CTRL_ON] |=> s_restart)
    else $error("hiccup did not restart");
  a_hiccup_length: assert property ($rose(q.st == ST_HICCUP) |-> q.hic_cnt == '0 ##1
                                    (q.st == ST_HICCUP)[*8])
    else $error("hiccup cut short");
  a_track_window: assert property ($rose(q.cause[C_TR]) |-> $past(q.st) == ST_RAMP_UP)
    else $error("tracking tripped outside ramp-up");
  a_sat_jump: assert property (cyc && running && q.sat_en && err_sample > SAT_WIN |=> q.duty == q.lim)
    else $error("saturation did not jump to limit");
  a_line_driven: assert property ($rose(q.self_flt) && q.ctrl[CTRL_GPROP] |-> !fault_line_oe_n)
    else $error("fault line not pulled low");

endmodule

/* File: tb/mgr_model.sv */
// partner: power manager on the fault, error and sync lines.
// assumes converter enables are low while it pulls a line.
`timescale 1ns/10ps
module mgr_model #(
  parameter int SYNC_HALF = 40
) (
  // clock
  input  wire logic hclk,
  // converter side
  input  wire logic fault_oe_n,
  input  wire logic err_oe_n,
  output logic      sync_line,
  output logic      fault_i,
  output logic      err_i,
  // bench side
  input  wire logic group_en,
  input  wire logic peer_fault_n,
  input  wire logic peer_error_n,
  output logic      other_off
);
  int   cnt    = 0;
  logic sync_q = 1'b0;
  // master clock runs free so the converter stays locked
  assign sync_line = sync_q;
  always @(posedge hclk) begin
    cnt <= (cnt == SYNC_HALF - 1) ? 0 : cnt + 1;
    if (cnt == SYNC_HALF - 1) sync_q <= ~sync_q;
  end
  // pulled-up open-drain lines: low while any party pulls
  assign fault_i = fault_oe_n & peer_fault_n;
  assign err_i = err_oe_n & peer_error_n;
  // a low group line is passed on to the other groups
  assign other_off = group_en & ~fault_i;
endmodule

/* File: tb/tb.sv */
// testbench: registers over ahb-lite, check inputs, shared lines.
// assumes mgr_model resolves the lines and makes the sync clock.
`timescale 1ns/10ps
module tb;
  import pol_pkg::*;
  localparam int HIC = 200;
  logic              hclk, hresetn, hsel, hwrite, hreadyout, sync_line;
  logic              fault_i, fault_oe_n, err_i, err_oe_n, hs_gate, ls_gate;
  logic              warn, peer_fault_n, peer_error_n, other_off, pg, hresp;
  logic [1:0]        htrans;
  logic [31:0]       haddr, hwdata, hrdata, rd;
  logic [7:0]        out_level;
  logic signed [7:0] err_sample;
  checks_t           meas;
  int                num_errors, checks, n;
  logic [7:0]        ra [3] = '{8'h00, 8'h08, 8'h0C};
  logic [31:0]       rv [3] = '{32'h18, 32'hC0, 32'h00080804};
  ////////////////////////////////////////////////////////////
  pol_fault_and_pwm_control #(.HICCUP_CYCLES(HIC)) dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sync_line(sync_line),
    .fault_line_i(fault_i), .fault_line_o(), .fault_line_oe_n(fault_oe_n),
    .error_line_i(err_i), .error_line_o(), .error_line_oe_n(err_oe_n),
    .checks(meas), .err_sample(err_sample), .hs_gate(hs_gate), .ls_gate(ls_gate),
    .out_level(out_level), .output_within_window(pg), .temperature_warning(warn));
  mgr_model mgr_u (
    .hclk(hclk), .fault_oe_n(fault_oe_n), .err_oe_n(err_oe_n), .sync_line(sync_line),
    .fault_i(fault_i), .err_i(err_i), .group_en(1'b1), .peer_fault_n(peer_fault_n),
    .peer_error_n(peer_error_n), .other_off(other_off));
  ////////////////////////////////////////////////////////////
  always #12.5 hclk = ~hclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // no limit of its own: only the watchdog ends a stuck wait
  task automatic rdy();
    do begin
      @(posedge hclk);
    end while (hreadyout !== 1'b1);
  endtask
  // address phase, then data phase; read data taken at the closing edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    rdy();
    rd = hrdata;
  endtask
  // polls the state code; slow but keeps the bus in use
  task automatic wait_st(input logic [2:0] s);
    int k;
    k = 0;
    do begin
      bus(1'b0, 8'h10, 32'h0);
      k++;
    end while (rd[10:8] !== s && k < 3000);
    chk(32'(rd[10:8]), 32'(s));
  endtask
  // clocks of high-side drive over one 500 kHz period, two periods after a change
  task automatic pulse_w(input int exp_w);
    int w;
    w = 0;
    repeat (160) @(posedge hclk);
    repeat (80) begin
      @(posedge hclk);
      if (hs_gate === 1'b1) w++;
    end
    chk(32'(w), 32'(exp_w));
  endtask
  task automatic close_out();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    #(25 * 50000);
    num_errors++;
    close_out();
  end
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    err_sample = 8'sh04;
    meas = 9'h181;
    peer_fault_n = 1'b1;
    peer_error_n = 1'b1;
    num_errors = 0;
    checks = 0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 3; i++) begin
      bus(1'b0, ra[i], 32'h0);
      chk(rd, rv[i]);
    end
    chk(32'(hresp), 32'h0);
    bus(1'b1, 8'h14, 32'hFFFFFFFF);
    bus(1'b0, 8'h14, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, 8'h04, 32'h22);
    bus(1'b1, 8'h04, 32'h23);
    bus(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h22);
    bus(1'b1, 8'h04, 32'h20);
    bus(1'b1, 8'h08, 32'h40);
    bus(1'b1, 8'h0C, 32'h00404000);
    bus(1'b1, 8'h00, 32'h1F);
    wait_st(3'h2);
    chk(32'(pg), 32'h1);
    bus(1'b1, 8'h04, 32'h21);
    bus(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h20);
    // sync edge to pwm edge, phase 0 and 8 steps
    for (int p = 0; p <= 8; p += 8) begin
      bus(1'b1, 8'h04, 32'(p << 2));
      repeat (300) @(posedge hclk);
      wait (sync_line === 1'b0);
      wait (sync_line === 1'b1);
      n = 0;
      do begin
        @(posedge hclk);
        n++;
      end while (hs_gate !== 1'b1 && n < 100);
      chk(32'(n >= (80 * p) / 32 + 2 && n <= (80 * p) / 32 + 6), 32'h1);
    end
    // feedforward: outside the window duty jumps, inside it creeps
    bus(1'b1, 8'h08, 32'h140);
    err_sample <= 8'shC0;
    pulse_w(0);
    err_sample <= 8'sh40;
    pulse_w(20);
    err_sample <= 8'shFC;
    pulse_w(19);
    err_sample <= 8'sh04;
    meas.overcurrent <= 1'b1;
    repeat (2) @(posedge hclk);
    chk(32'({hs_gate, ls_gate, out_level}), 32'h0);
    wait_st(3'h5);
    chk(32'(fault_oe_n), 32'h0);
    meas.overcurrent <= 1'b0;
    wait_st(3'h2);
    meas.warm <= 1'b1;
    repeat (3) @(posedge hclk);
    chk(32'(warn), 32'h1);
    wait_st(3'h2);
    meas.warm <= 1'b0;
    meas.low_output <= 1'b1;
    wait_st(3'h3);
    chk(32'(fault_oe_n), 32'h0);
    chk(32'(pg), 32'h0);
    chk(32'(other_off), 32'h1);
    wait_st(3'h4);
    // hiccup span must not follow the turn-off delay
    for (int k = 0; k < 2; k++) begin
      bus(1'b1, 8'h0C, 32'h00404000 | 32'(k * 8));
      n = 0;
      while (out_level !== 8'h00 && n < 20000) begin
        @(posedge hclk);
        n++;
      end
      n = 0;
      while (out_level === 8'h00 && n < 2000) begin
        @(posedge hclk);
        n++;
      end
      chk(32'(n >= HIC && n <= HIC + 100), 32'h1);
    end
    meas.low_output <= 1'b0;
    wait_st(3'h2);
    peer_fault_n <= 1'b0;
    wait_st(3'h3);
    peer_fault_n <= 1'b1;
    wait_st(3'h2);
    meas.high_output <= 1'b1;
    repeat (2) @(posedge hclk);
    chk(32'({hs_gate, ls_gate, out_level}), 32'h100);
    chk(32'(err_oe_n), 32'h0);
    wait_st(3'h6);
    meas.high_output <= 1'b0;
    bus(1'b1, 8'h00, 32'h1E);
    wait_st(3'h0);
    meas.track_miss <= 1'b1;
    bus(1'b1, 8'h00, 32'h1F);
    wait_st(3'h5);
    chk(32'(rd[C_TR]), 32'h1);
    meas.track_miss <= 1'b0;
    wait_st(3'h2);
    peer_error_n <= 1'b0;
    repeat (2) @(posedge hclk);
    chk(32'({hs_gate, out_level}), 32'h0);
    close_out();
  end
endmodule
